// >>> hdl/ofc_params.svh
/*
 Constants of the output frame composer: byte addresses, field
 positions, reset values, pattern codes and frame sizes.
 Assumes inclusion by ofc_pkg and by both design modules.
*/
// Operation
// - Control bit 14 appends 4-bit node address
// - Bits 13-12 pick supply alarm flags appended
// - Bits 11-10 pick input alarm flags appended
// - Bit 8 appends the 4-bit range code
// - Bit 3 appends two parity bits last
// - Result parity: even over result bits only
// - Frame parity: even over all frame bits before the two parity bits
// - Parity lengthens frame by exactly two bits
// - Codes 0xx result, 100 zeros, 101 ones
// - 110 alternating bits, 111 alternating pairs
// - Reserved bits ignore writes, read zero
// - Parity enable, range code clear on power-on only
// - Control register bytes at 10h to 13h
// - Range register bytes at 14h to 17h
// - Reference-off bit 6, range code 3:0
// - Reference-off one stops internal reference
// - Range codes select bipolar or unipolar spans
`ifndef OFC_PARAMS_SVH
`define OFC_PARAMS_SVH
`define OFC_ADDR_CTL_B0 8'h10
`define OFC_ADDR_CTL_B1 8'h11
`define OFC_ADDR_CTL_B2 8'h12
`define OFC_ADDR_CTL_B3 8'h13
`define OFC_ADDR_RNG_B0 8'h14
`define OFC_ADDR_RNG_B1 8'h15
`define OFC_ADDR_RNG_B2 8'h16
`define OFC_ADDR_RNG_B3 8'h17
`define OFC_CTL_NODE     14
`define OFC_CTL_SUP_LO   13
`define OFC_CTL_SUP_HI   12
`define OFC_CTL_IN_LO    11
`define OFC_CTL_IN_HI    10
`define OFC_CTL_RANGE    8
`define OFC_CTL_PARITY   3
`define OFC_CTL_PAT_MSB  2
`define OFC_RNG_REF_OFF  6
`define OFC_RNG_CODE_MSB 3
`define OFC_BYTE1_BASE   8
`define OFC_PAT_ZEROS 2'h0
`define OFC_PAT_ONES  2'h1
`define OFC_PAT_ALT1  2'h2
`define OFC_PAT_ALT2  2'h3
`define OFC_RST_BIT   1'h0
`define OFC_RST_SEL_N 1'h1
`define OFC_RST_SEL   2'h0
`define OFC_RST_PAT   3'h0
`define OFC_RST_CODE  4'h0
`define OFC_RST_BYTE  8'h00
`define OFC_NODE_W    4
`define OFC_RANGE_W   4
`define OFC_FIELDS_W  18
`define OFC_FRAME_MAX 32
`define OFC_LEN_W     6
`endif

// >>> hdl/ofc_pkg.sv
/*
 Types shared by the output frame composer and its serialiser.
 Assumes ofc_params.svh is on the include path.
*/
`include "ofc_params.svh"
package ofc_pkg;
    typedef struct packed {
        logic sup_hi;
        logic sup_lo;
        logic in_hi;
        logic in_lo;
    } ofc_alarm_t;

    typedef struct packed {
        logic [`OFC_FRAME_MAX-1:0] bits;
        logic [`OFC_LEN_W-1:0]     len;
    } ofc_frame_t;
endpackage

// >>> hdl/ofc_bit_shifter.sv
/*
 Serialiser: loads a left-aligned frame and shifts it out MSB first.
 Assumes load and shift strobes are one-cycle pulses on clock_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ofc_params.svh"
module ofc_bit_shifter
    import ofc_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    input  wire logic       load_in,
    input  wire logic       shift_in,
    input  wire ofc_frame_t frame_in,
    output logic            bit_out,
    output logic            busy_out
);
    logic [`OFC_FRAME_MAX-1:0] shreg_r;
    logic [`OFC_LEN_W-1:0]     left_r;
    logic                      more_w;

    assign more_w   = (left_r != '0);
    assign bit_out  = shreg_r[`OFC_FRAME_MAX-1];
    assign busy_out = more_w;

    // Zeros follow the last frame bit
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            shreg_r <= '0;
            left_r  <= '0;
        end else if (load_in) begin
            shreg_r <= frame_in.bits;
            left_r  <= frame_in.len;
        end else if (shift_in && more_w) begin
            shreg_r <= {shreg_r[`OFC_FRAME_MAX-2:0], 1'b0};
            left_r  <= left_r - `OFC_LEN_W'(1);
        end
    end
endmodule
`default_nettype wire

// >>> hdl/ofc_frame_composer.sv
/*
 Output frame composer: output-control and range-select registers,
 frame assembly with optional fields and parity, serial output.
 Assumes a byte-wide register port on clock_in, an SPI mode-0 reader
 whose clock and select arrive asynchronously, and alarm flags,
 node address and conversion result from logic on clock_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ofc_params.svh"
module ofc_frame_composer
    import ofc_pkg::*;
#(
    parameter int RESULT_W = 14
) (
    input  wire logic                    clock_in,
    input  wire logic                    rst_n_in,
    input  wire logic                    por_n_in,
    input  wire logic [7:0]              reg_addr_in,
    input  wire logic [7:0]              reg_wdata_in,
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    output logic      [7:0]              reg_rdata_out,
    input  wire logic [RESULT_W-1:0]     result_in,
    input  wire logic [`OFC_NODE_W-1:0]  node_address_in,
    input  wire ofc_alarm_t              alarm_in,
    input  wire logic                    sclk_in,
    input  wire logic                    cs_n_in,
    output logic                         serial_out_lines_out,
    output logic                         serial_out_oe_n_out,
    output logic                         frame_busy_out,
    output logic                         internal_reference_off_out,
    output logic [`OFC_RANGE_W-1:0]      range_code_out
);
    localparam int MAXW = `OFC_FRAME_MAX;
    localparam int LW   = `OFC_LEN_W;

    generate
        if (RESULT_W < 2 || RESULT_W + `OFC_FIELDS_W > MAXW) begin : g_bad_width
            $error("RESULT_W does not fit the frame");
        end
    endgenerate

    // Control state
    logic                     node_app_r;
    logic                     sup_hi_app_r;
    logic                     sup_lo_app_r;
    logic                     in_hi_app_r;
    logic                     in_lo_app_r;
    logic                     range_app_r;
    logic                     parity_en_r;
    logic [2:0]               pat_sel_r;
    logic                     ref_off_r;
    logic [`OFC_RANGE_W-1:0]  range_code_r;
    logic [7:0]               rdata_r;

    // Register decode
    logic        hit_ctl0_w;
    logic        hit_ctl1_w;
    logic        hit_ctl2_w;
    logic        hit_ctl3_w;
    logic        hit_rng0_w;
    logic        hit_rng1_w;
    logic        hit_rng2_w;
    logic        hit_rng3_w;
    logic        wr_ctl0_w;
    logic        wr_ctl1_w;
    logic        wr_rng0_w;
    logic        app_clr_w;
    logic        por_clr_w;
    logic [31:0] ctl_word_w;
    logic [31:0] rng_word_w;
    logic [7:0]  rd_byte_w;

    // One select per byte address; unmatched addresses read zero
    assign hit_ctl0_w = (reg_addr_in == `OFC_ADDR_CTL_B0);
    assign hit_ctl1_w = (reg_addr_in == `OFC_ADDR_CTL_B1);
    assign hit_ctl2_w = (reg_addr_in == `OFC_ADDR_CTL_B2);
    assign hit_ctl3_w = (reg_addr_in == `OFC_ADDR_CTL_B3);
    assign hit_rng0_w = (reg_addr_in == `OFC_ADDR_RNG_B0);
    assign hit_rng1_w = (reg_addr_in == `OFC_ADDR_RNG_B1);
    assign hit_rng2_w = (reg_addr_in == `OFC_ADDR_RNG_B2);
    assign hit_rng3_w = (reg_addr_in == `OFC_ADDR_RNG_B3);

    assign app_clr_w = !rst_n_in || !por_n_in;
    assign por_clr_w = !por_n_in;
    assign wr_ctl0_w = reg_wr_in && hit_ctl0_w;
    assign wr_ctl1_w = reg_wr_in && hit_ctl1_w;
    assign wr_rng0_w = reg_wr_in && hit_rng0_w;

    // Parity enable and pattern select, low byte
    always_ff @(posedge clock_in) begin
        if (por_clr_w) begin
            parity_en_r <= `OFC_RST_BIT;
        end else if (wr_ctl0_w) begin
            parity_en_r <= reg_wdata_in[`OFC_CTL_PARITY];
        end
    end

    always_ff @(posedge clock_in) begin
        if (app_clr_w) begin
            pat_sel_r <= `OFC_RST_PAT;
        end else if (wr_ctl0_w) begin
            pat_sel_r <= reg_wdata_in[`OFC_CTL_PAT_MSB:0];
        end
    end

    // Field appends, second byte; bits 15 and 9 are not stored
    always_ff @(posedge clock_in) begin
        if (app_clr_w) begin
            node_app_r   <= `OFC_RST_BIT;
            sup_hi_app_r <= `OFC_RST_BIT;
            sup_lo_app_r <= `OFC_RST_BIT;
            in_hi_app_r  <= `OFC_RST_BIT;
            in_lo_app_r  <= `OFC_RST_BIT;
            range_app_r  <= `OFC_RST_BIT;
        end else if (wr_ctl1_w) begin
            node_app_r   <= reg_wdata_in[`OFC_CTL_NODE - `OFC_BYTE1_BASE];
            sup_hi_app_r <= reg_wdata_in[`OFC_CTL_SUP_HI - `OFC_BYTE1_BASE];
            sup_lo_app_r <= reg_wdata_in[`OFC_CTL_SUP_LO - `OFC_BYTE1_BASE];
            in_hi_app_r  <= reg_wdata_in[`OFC_CTL_IN_HI - `OFC_BYTE1_BASE];
            in_lo_app_r  <= reg_wdata_in[`OFC_CTL_IN_LO - `OFC_BYTE1_BASE];
            range_app_r  <= reg_wdata_in[`OFC_CTL_RANGE - `OFC_BYTE1_BASE];
        end
    end

    // Range-select register
    always_ff @(posedge clock_in) begin
        if (app_clr_w) begin
            ref_off_r <= `OFC_RST_BIT;
        end else if (wr_rng0_w) begin
            ref_off_r <= reg_wdata_in[`OFC_RNG_REF_OFF];
        end
    end

    always_ff @(posedge clock_in) begin
        if (por_clr_w) begin
            range_code_r <= `OFC_RST_CODE;
        end else if (wr_rng0_w) begin
            range_code_r <= reg_wdata_in[`OFC_RNG_CODE_MSB:0];
        end
    end

    // Reserved positions are constant zero
    always_comb begin
        ctl_word_w = '0;
        ctl_word_w[`OFC_CTL_NODE]   = node_app_r;
        ctl_word_w[`OFC_CTL_SUP_LO] = sup_lo_app_r;
        ctl_word_w[`OFC_CTL_SUP_HI] = sup_hi_app_r;
        ctl_word_w[`OFC_CTL_IN_LO]  = in_lo_app_r;
        ctl_word_w[`OFC_CTL_IN_HI]  = in_hi_app_r;
        ctl_word_w[`OFC_CTL_RANGE]  = range_app_r;
        ctl_word_w[`OFC_CTL_PARITY] = parity_en_r;
        ctl_word_w[`OFC_CTL_PAT_MSB:0] = pat_sel_r;
    end

    always_comb begin
        rng_word_w = '0;
        rng_word_w[`OFC_RNG_REF_OFF]    = ref_off_r;
        rng_word_w[`OFC_RNG_CODE_MSB:0] = range_code_r;
    end

    assign rd_byte_w =
        hit_ctl0_w ? ctl_word_w[7:0]   :
        hit_ctl1_w ? ctl_word_w[15:8]  :
        hit_ctl2_w ? ctl_word_w[23:16] :
        hit_ctl3_w ? ctl_word_w[31:24] :
        hit_rng0_w ? rng_word_w[7:0]   :
        hit_rng1_w ? rng_word_w[15:8]  :
        hit_rng2_w ? rng_word_w[23:16] :
        hit_rng3_w ? rng_word_w[31:24] :
        `OFC_RST_BYTE;

    // Read data one cycle after the strobe, held until the next read
    always_ff @(posedge clock_in) begin
        if (app_clr_w) begin
            rdata_r <= `OFC_RST_BYTE;
        end else if (reg_rd_in) begin
            rdata_r <= rd_byte_w;
        end
    end

    assign reg_rdata_out              = rdata_r;
    assign internal_reference_off_out = ref_off_r;
    assign range_code_out             = range_code_r;

    // Test patterns, MSB first: 0101... and 0011...
    logic [RESULT_W-1:0] alt1_w;
    logic [RESULT_W-1:0] alt2_w;
    logic [RESULT_W-1:0] payload_w;
    logic                pat_live_w;
    logic [1:0]          pat_code_w;

    generate
        for (genvar g = 0; g < RESULT_W; g++) begin : g_pat
            localparam int D = RESULT_W - 1 - g;
            assign alt1_w[g] = 1'((D % 2) != 0);
            assign alt2_w[g] = 1'(((D / 2) % 2) != 0);
        end
    endgenerate

    assign pat_live_w = !pat_sel_r[`OFC_CTL_PAT_MSB];
    assign pat_code_w = pat_sel_r[`OFC_CTL_PAT_MSB-1:0];
    assign payload_w =
        pat_live_w ? result_in :
        (pat_code_w == `OFC_PAT_ZEROS) ? '0 :
        (pat_code_w == `OFC_PAT_ONES)  ? '1 :
        (pat_code_w == `OFC_PAT_ALT1)  ? alt1_w :
        alt2_w;

    // Frame assembly, right-aligned, then moved to the top
    logic [MAXW-1:0] asm_v;
    logic [LW-1:0]   len_v;
    logic            res_par_v;
    logic            frm_par_v;
    ofc_frame_t      frame_w;

    always_comb begin
        asm_v     = '0;
        len_v     = LW'(RESULT_W);
        res_par_v = ^payload_w;
        frm_par_v = 1'b0;
        asm_v[RESULT_W-1:0] = payload_w;
        if (node_app_r) begin
            asm_v = {asm_v[MAXW-`OFC_NODE_W-1:0], node_address_in};
            len_v = len_v + LW'(`OFC_NODE_W);
        end
        if (sup_hi_app_r) begin
            asm_v = {asm_v[MAXW-2:0], alarm_in.sup_hi};
            len_v = len_v + LW'(1);
        end
        if (sup_lo_app_r) begin
            asm_v = {asm_v[MAXW-2:0], alarm_in.sup_lo};
            len_v = len_v + LW'(1);
        end
        if (in_hi_app_r) begin
            asm_v = {asm_v[MAXW-2:0], alarm_in.in_hi};
            len_v = len_v + LW'(1);
        end
        if (in_lo_app_r) begin
            asm_v = {asm_v[MAXW-2:0], alarm_in.in_lo};
            len_v = len_v + LW'(1);
        end
        if (range_app_r) begin
            asm_v = {asm_v[MAXW-`OFC_RANGE_W-1:0], range_code_r};
            len_v = len_v + LW'(`OFC_RANGE_W);
        end
        frm_par_v = ^asm_v;
        if (parity_en_r) begin
            asm_v = {asm_v[MAXW-3:0], res_par_v, frm_par_v};
            len_v = len_v + LW'(2);
        end
        frame_w.bits = asm_v << (LW'(MAXW) - len_v);
        frame_w.len  = len_v;
    end

    // Link inputs: two flip-flops, then an edge-history stage
    logic sclk_s1_r;
    logic sclk_s2_r;
    logic sclk_s3_r;
    logic cs_n_s1_r;
    logic cs_n_s2_r;
    logic cs_n_s3_r;
    logic cs_fall_w;
    logic sclk_fall_w;

    always_ff @(posedge clock_in) begin
        if (app_clr_w) begin
            sclk_s1_r <= `OFC_RST_BIT;
            sclk_s2_r <= `OFC_RST_BIT;
            sclk_s3_r <= `OFC_RST_BIT;
            cs_n_s1_r <= `OFC_RST_SEL_N;
            cs_n_s2_r <= `OFC_RST_SEL_N;
            cs_n_s3_r <= `OFC_RST_SEL_N;
        end else begin
            sclk_s1_r <= sclk_in;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            cs_n_s1_r <= cs_n_in;
            cs_n_s2_r <= cs_n_s1_r;
            cs_n_s3_r <= cs_n_s2_r;
        end
    end

    assign cs_fall_w   = cs_n_s3_r && !cs_n_s2_r;
    assign sclk_fall_w = sclk_s3_r && !sclk_s2_r && !cs_n_s2_r;

    // Frame captured as select falls; first bit shows at once
    ofc_bit_shifter u_shifter (
        .clock_in (clock_in),
        .rst_n_in (!app_clr_w),
        .load_in  (cs_fall_w),
        .shift_in (sclk_fall_w),
        .frame_in (frame_w),
        .bit_out  (serial_out_lines_out),
        .busy_out (frame_busy_out)
    );

    // Line driven while select is low
    assign serial_out_oe_n_out = cs_n_s2_r;
endmodule
`default_nettype wire

// >>> testbench/ofc_monitor.sv
/*
 Register and read-back checks of the frame composer at its ports.
 Assumes a bind to ofc_frame_composer, everything on clock_in.
*/
`timescale 1ns/1ps
`default_nettype none
module ofc_monitor
    import ofc_pkg::*;
(
    input wire logic       clock_in,
    input wire logic       rst_n_in,
    input wire logic       por_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       internal_reference_off_out,
    input wire logic [3:0] range_code_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in || !por_n_in);
    wire logic wr_rng  = reg_wr_in && reg_addr_in == 8'h14;
    wire logic rd_ctl  = reg_rd_in && reg_addr_in == 8'h10;
    wire logic rd_zero = reg_rd_in && !(reg_addr_in inside {8'h10, 8'h11, 8'h14});
    wire logic rst_any = !rst_n_in || !por_n_in;

    property p_ref_write;
        wr_rng |=> internal_reference_off_out == $past(reg_wdata_in[6]);
    endproperty
    a_ref_write: assert property (p_ref_write)
        else $error("reference-off bit did not take the written value");
    property p_range_write;
        wr_rng |=> range_code_out == $past(reg_wdata_in[3:0]);
    endproperty
    a_range_write: assert property (p_range_write)
        else $error("range code did not take the written value");
    property p_ref_hold;
        !$stable(internal_reference_off_out) |-> $past(wr_rng) || $past(rst_any);
    endproperty
    a_ref_hold: assert property (p_ref_hold)
        else $error("reference-off bit changed without a write");
    property p_range_hold;
        $changed(range_code_out) |-> $past(wr_rng) || $past(rst_any);
    endproperty
    a_range_hold: assert property (p_range_hold)
        else $error("range code changed without a write");
    property p_rd_range;
        reg_rd_in && reg_addr_in == 8'h14 |=> reg_rdata_out ==
            {1'b0, $past(internal_reference_off_out), 2'b00, $past(range_code_out)};
    endproperty
    a_rd_range: assert property (p_rd_range)
        else $error("range register read back wrong");
    property p_rd_zero;
        rd_zero |=> reg_rdata_out == 8'h00;
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("reserved byte read nonzero");
    property p_wr_rd_ctl;
        (reg_wr_in && reg_addr_in == 8'h10) ##2 rd_ctl
            |=> reg_rdata_out == {4'h0, $past(reg_wdata_in[3:0], 3)};
    endproperty
    a_wr_rd_ctl: assert property (p_wr_rd_ctl)
        else $error("control low byte read back wrong");
    property p_por_clear;
        @(posedge clock_in) disable iff (!rst_n_in)
        !por_n_in |=> range_code_out == 4'h0 && !internal_reference_off_out;
    endproperty
    a_por_clear: assert property (p_por_clear)
        else $error("power-on reset left range register set");
    property p_ctl_hi_zero;
        reg_rd_in && reg_addr_in == 8'h11 |=> !reg_rdata_out[7] && !reg_rdata_out[1];
    endproperty
    a_ctl_hi_zero: assert property (p_ctl_hi_zero)
        else $error("reserved control bits read nonzero");
    c_rng_write: cover property (wr_rng);
    c_rd_zero: cover property (rd_zero);
    c_por: cover property (@(posedge clock_in) disable iff (!rst_n_in)
        !por_n_in ##1 por_n_in);
endmodule
`default_nettype wire

// >>> testbench/ofc_host_model.sv
/*
 Host reader: SPI mode 0, MSB first, clock still between frames.
 Assumes the device shifts on the falling serial clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ofc_host_model (
    input  wire logic sdo_in,
    input  wire logic oe_n_in,
    output var logic  sclk_out,
    output var logic  cs_n_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
    end
    // Slow frames wait longer before the first edge; 48 ns period while clocking
    task automatic read_frame(input int n, input bit slow, output logic [31:0] f);
        f = 32'h0;
        #1.3 cs_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            #((slow && i == 0) ? 80 : 32) sclk_out = 1'b1;
            f = {f[30:0], oe_n_in ? 1'bx : sdo_in};
            #16 sclk_out = 1'b0;
        end
        #16 cs_n_out = 1'b1;
        #30 f = f << (32 - n);
    endtask
endmodule
`default_nettype wire

// >>> testbench/adc_output_frame_composer_tb_top.sv
/*
 Testbench of the frame composer: table of frame settings, then
 reserved bits, application reset and power-on reset.
 Assumes ofc_pkg compiled first and a 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_output_frame_composer_tb_top;
    import ofc_pkg::*;
    typedef struct packed {
        logic [7:0]  c0;
        logic [7:0]  c1;
        logic [7:0]  rg;
        logic [13:0] res;
        logic [3:0]  node;
        ofc_alarm_t  al;
        logic [5:0]  len;
    } ofc_row_t;
    logic       clock_in, rst_n_in, por_n_in, reg_wr_in, reg_rd_in;
    logic       sclk, cs_n, sdo, oe_n, busy, ref_off;
    logic [7:0] reg_addr_in, reg_wdata_in, rdata;
    logic [13:0] result;
    logic [3:0] node, rng;
    ofc_alarm_t alarm;
    int         n_fail = 0;
    int         check_count = 0;
    ofc_row_t rows[8] = '{
        '{8'h00, 8'h00, 8'h00, 14'h1234, 4'h5, 4'h0, 6'd14},
        '{8'h08, 8'h40, 8'h49, 14'h0f0f, 4'ha, 4'h0, 6'd20},
        '{8'h04, 8'h10, 8'h00, 14'h0001, 4'h3, 4'hf, 6'd15},
        '{8'h05, 8'h20, 8'h41, 14'h2222, 4'h0, 4'h4, 6'd15},
        '{8'h0e, 8'h3c, 8'h02, 14'h3fff, 4'h1, 4'ha, 6'd20},
        '{8'h0f, 8'h05, 8'h09, 14'h0000, 4'h2, 4'h3, 6'd21},
        '{8'h0b, 8'h7d, 8'h0b, 14'h2aaa, 4'hc, 4'h6, 6'd28},
        '{8'h02, 8'h09, 8'h04, 14'h1abc, 4'h7, 4'h9, 6'd19}};
    logic [23:0] rw[7] = '{24'h10ff0f, 24'h11ff7d, 24'h12ff00, 24'h13ff00,
                           24'h14ff4f, 24'h17ff00, 24'h20ff00};

    ofc_frame_composer #(.RESULT_W(14)) i_ofc_frame_composer (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata),
        .result_in(result), .node_address_in(node), .alarm_in(alarm),
        .sclk_in(sclk), .cs_n_in(cs_n), .serial_out_lines_out(sdo),
        .serial_out_oe_n_out(oe_n), .frame_busy_out(busy),
        .internal_reference_off_out(ref_off), .range_code_out(rng));
    ofc_host_model i_ofc_host_model (
        .sdo_in(sdo), .oe_n_in(oe_n), .sclk_out(sclk), .cs_n_out(cs_n));

    function automatic logic [13:0] pay(logic [2:0] s, logic [13:0] r);
        case (s)
            3'h4: pay = 14'h0000;
            3'h5: pay = 14'h3fff;
            3'h6: pay = 14'h1555;
            3'h7: pay = 14'h0ccc;
            default: pay = r;
        endcase
    endfunction
    function automatic ofc_frame_t mk(logic [13:0] p, ofc_row_t r);
        logic [31:0] b;
        logic [5:0]  n;
        b = {18'h0, p};
        if (r.c1[6]) b = {b[27:0], r.node};
        if (r.c1[4]) b = {b[30:0], r.al.sup_hi};
        if (r.c1[5]) b = {b[30:0], r.al.sup_lo};
        if (r.c1[2]) b = {b[30:0], r.al.in_hi};
        if (r.c1[3]) b = {b[30:0], r.al.in_lo};
        if (r.c1[0]) b = {b[27:0], r.rg[3:0]};
        if (r.c0[3]) b = {b[29:0], ^p, ^b};
        n = 6'(14 + 4 * r.c1[6] + r.c1[4] + r.c1[5] + r.c1[2] + r.c1[3]
               + 4 * r.c1[0] + 2 * r.c0[3]);
        mk.bits = b << (6'd32 - n);
        mk.len = n;
    endfunction
    task automatic conclude();
        if (n_fail == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        #1 chk({24'h0, rdata}, {24'h0, exp});
    endtask
    task automatic pulse_reset(input bit por);
        @(posedge clock_in);
        if (por) por_n_in <= 1'b0;
        else rst_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        por_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
    endtask
    task automatic frame(input ofc_row_t r, input bit slow);
        logic [31:0] got;
        ofc_frame_t  e0;
        int          k;
        e0 = mk(pay(r.c0[2:0], r.res), r);
        wr(8'h10, r.c0);
        wr(8'h11, r.c1);
        wr(8'h14, r.rg);
        result <= r.res;
        node <= r.node;
        alarm <= r.al;
        @(posedge clock_in);
        #1 chk({28'h0, rng}, {28'h0, r.rg[3:0]});
        chk({31'h0, ref_off}, {31'h0, r.rg[6]});
        i_ofc_host_model.read_frame(int'(r.len), slow, got);
        chk(got, e0.bits);
        for (k = 0; k < 20 && busy !== 1'b0; k++) @(posedge clock_in);
        if (k == 20) begin
            n_fail++;
            conclude();
        end
    endtask

    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    initial begin
        {rst_n_in, por_n_in, reg_wr_in, reg_rd_in} = 4'h0;
        {reg_addr_in, reg_wdata_in, result, node, alarm} = 38'h0;
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        por_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        rd(8'h14, 8'h00);
        for (int i = 0; i < 8; i++) frame(rows[i], i[0]);
        for (int i = 0; i < 7; i++) begin
            wr(rw[i][23:16], rw[i][15:8]);
            rd(rw[i][23:16], rw[i][7:0]);
        end
        pulse_reset(1'b0);
        rd(8'h10, 8'h08);
        rd(8'h11, 8'h00);
        rd(8'h14, 8'h0f);
        pulse_reset(1'b1);
        rd(8'h10, 8'h00);
        rd(8'h14, 8'h00);
        conclude();
    end
endmodule

bind ofc_frame_composer ofc_monitor i_ofc_monitor (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .internal_reference_off_out(internal_reference_off_out),
    .range_code_out(range_code_out));
`default_nettype wire
